// >>> logic/arc_analog_remote_ctrl.sv
`default_nettype none
// Function
// - Analog set values act only in remote; standby pin always acts.
// - Set and actual values share 26214 steps at 10 V, half at 5 V.
// - Set values and control pins are acquired once per 2 ms.
// - Any device alarm switches the DC input off.
// - Latched alarms clear after high-low-high standby, low at least 50 ms.
// - Remote-select low requests remote; high or open means internal.
// - First alarm pin high while overtemperature or power fail present.
// - Resistance set value used only while resistance-mode pin is low.
// - Standby low turns input off unless polarity is inverted; acknowledges alarms only in remote.
// - Second alarm pin high while any latched alarm is present.
// - Status pin low in constant voltage, high in other regulations.
// - Status pin shows regulation or input state, chosen by setting.
// - Both voltage ranges map linearly onto 0 to 100 percent.
// - Samples above full scale are clamped to 100 percent.
// - Voltage, current and power set values switch source together.
// - Outside remote, standby low (high when inverted) locks the DC input off.
module arc_analog_remote_ctrl #(
   parameter int unsigned SAMPLE_CYCLES = arc_pkg::SAMPLE_CYCLES,
   parameter int unsigned VAL_W = arc_pkg::VAL_W
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Socket digital pins
   input wire logic remoteSel_b,
   input wire logic resistanceMode_b,
   input wire logic input_standby_pin,
   output logic alarmPin1,
   output logic alarmPin2,
   output logic statusPin,
   // Converted analog values
   input wire logic [VAL_W-1:0] voltage_setpoint_in,
   input wire logic [VAL_W-1:0] current_setpoint_in,
   input wire logic [VAL_W-1:0] powerSetpointIn,
   input wire logic [VAL_W-1:0] resistance_setpoint_in,
   input wire logic [VAL_W-1:0] actualVoltage,
   input wire logic [VAL_W-1:0] actualCurrent,
   output logic [VAL_W-1:0] voltage_monitor_out,
   output logic [VAL_W-1:0] current_monitor_out,
   // Regulator side
   input wire logic overvoltage_alarm,
   input wire logic overcurrent_alarm,
   input wire logic overpower_alarm,
   input wire logic overtemperature_alarm,
   input wire logic power_fail_alarm,
   input wire arc_pkg::arc_reg_mode_t regMode,
   output logic [VAL_W-1:0] setVoltage,
   output logic [VAL_W-1:0] setCurrent,
   output logic [VAL_W-1:0] setPower,
   output logic [VAL_W-1:0] setResistance,
   output logic dcInputOn,
   output logic remoteActive
);
   localparam int unsigned CW = $clog2(SAMPLE_CYCLES);
   localparam logic [VAL_W-1:0] FS10 = VAL_W'(arc_pkg::FULL_SCALE_10V);
   localparam logic [VAL_W-1:0] FS5 = VAL_W'(arc_pkg::FULL_SCALE_5V);

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   // Clamp a sample and stretch it onto the full-scale span
   function automatic logic [VAL_W-1:0] toPercent(
      input logic [VAL_W-1:0] raw, input logic r5);
      logic [VAL_W-1:0] fs;
      logic [VAL_W-1:0] c;
      fs = r5 ? FS5 : FS10;
      c = (raw > fs) ? fs : raw;
      return r5 ? {c[VAL_W-2:0], 1'b0} : c;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Sample tick divider
   logic [CW-1:0] tickCnt_reg;
   logic sampleTick_reg;
   wire tickLast = (tickCnt_reg == CW'(SAMPLE_CYCLES - 1));
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tickCnt_reg <= '0;
         sampleTick_reg <= 1'b0;
      end else begin
         tickCnt_reg <= tickLast ? '0 : tickCnt_reg + 1'b1;
         sampleTick_reg <= tickLast;
      end
   end

   // Pin synchronisers
   logic [2:0] pinS;
   arc_pin_sample #(.W(3)) uPins (
      .mclk(mclk),
      .rst_b(rst_b),
      .sampleTick(sampleTick_reg),
      .pinIn({input_standby_pin, resistanceMode_b, remoteSel_b}),
      .pinSampled(pinS)
   );

   // AXI4-Lite channels
   logic awHeld_reg, wHeld_reg, awReady_reg, wReady_reg, bValid_reg;
   logic arReady_reg, rValid_reg;
   logic [7:0] awAddr_reg;
   logic [31:0] wData_reg, rData_reg;
   logic [3:0] wStrb_reg;
   logic [1:0] bResp_reg, rResp_reg;
   wire awTake = s_axi_awvalid & awReady_reg;
   wire wTake = s_axi_wvalid & wReady_reg;
   wire doWrite = awHeld_reg & wHeld_reg & ~bValid_reg;
   wire awHeldNext = (awHeld_reg & ~doWrite) | awTake;
   wire wHeldNext = (wHeld_reg & ~doWrite) | wTake;
   wire bValidNext = doWrite | (bValid_reg & ~s_axi_bready);
   wire arTake = s_axi_arvalid & arReady_reg;
   wire rValidNext = arTake | (rValid_reg & ~s_axi_rready);
   wire wrCtrl = doWrite & (awAddr_reg == arc_pkg::REG_CTRL);
   wire wrPanVI = doWrite & (awAddr_reg == arc_pkg::REG_PANEL_VI);
   wire wrPanPR = doWrite & (awAddr_reg == arc_pkg::REG_PANEL_PR);
   wire wrOk = wrCtrl | wrPanVI | wrPanPR;

   // Software registers
   logic [2:0] ctrl_reg;
   logic [31:0] panelVI_reg, panelPR_reg;
   wire ctrlLane = wrCtrl & wStrb_reg[0];
   wire range5 = ctrl_reg[arc_pkg::CTRL_RANGE5_BIT];
   wire showInput = ctrl_reg[arc_pkg::CTRL_SHOWIN_BIT];
   wire sbInvert = ctrl_reg[arc_pkg::CTRL_SBINV_BIT];
   wire cmdOn = ctrlLane & wData_reg[arc_pkg::CTRL_ON_BIT];
   wire cmdOff = ctrlLane & wData_reg[arc_pkg::CTRL_OFF_BIT];
   wire swAck = ctrlLane & wData_reg[arc_pkg::CTRL_ACK_BIT];

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         awReady_reg <= 1'b0;
         wReady_reg <= 1'b0;
         bValid_reg <= 1'b0;
         bResp_reg <= arc_pkg::RESP_OKAY;
         awAddr_reg <= 8'h00;
         wData_reg <= 32'h0;
         wStrb_reg <= 4'h0;
      end else begin
         awHeld_reg <= awHeldNext;
         wHeld_reg <= wHeldNext;
         awReady_reg <= ~awHeldNext & ~bValidNext;
         wReady_reg <= ~wHeldNext & ~bValidNext;
         bValid_reg <= bValidNext;
         if (doWrite) begin
            bResp_reg <= wrOk ? arc_pkg::RESP_OKAY : arc_pkg::RESP_SLVERR;
         end
         if (awTake) begin
            awAddr_reg <= s_axi_awaddr;
         end
         if (wTake) begin
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_reg <= arc_pkg::CTRL_RESET;
         panelVI_reg <= 32'h0;
         panelPR_reg <= 32'h0;
      end else begin
         if (ctrlLane) begin
            ctrl_reg <= wData_reg[2:0];
         end
         if (wrPanVI) begin
            panelVI_reg <= merge(panelVI_reg, wData_reg, wStrb_reg);
         end
         if (wrPanPR) begin
            panelPR_reg <= merge(panelPR_reg, wData_reg, wStrb_reg);
         end
      end
   end

   // Control decisions
   localparam int unsigned LOW_W_L = arc_pkg::LOW_W;
   logic [LOW_W_L-1:0] lowCnt_reg;
   logic [2:0] almLat_reg;
   wire remoteReq = ~pinS[0];
   wire rModeActive = ~pinS[1];
   wire standbyOn = pinS[2] ^ sbInvert;
   wire lowLong = lowCnt_reg >= LOW_W_L'(arc_pkg::ACK_LOW_SAMPLES);
   wire ackPin = sampleTick_reg & standbyOn & lowLong & remoteActive;
   wire ackNow = ackPin | swAck;
   wire [2:0] almEvt = {overpower_alarm, overcurrent_alarm,
      overvoltage_alarm};
   wire anyAlarm = (|almLat_reg) | overtemperature_alarm | power_fail_alarm;
   wire dcOnNext = anyAlarm ? 1'b0 :
      remoteActive ? standbyOn :
      ~standbyOn ? 1'b0 :
      cmdOn ? 1'b1 : cmdOff ? 1'b0 : dcInputOn;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         lowCnt_reg <= '0;
         almLat_reg <= 3'h0;
         remoteActive <= 1'b0;
         dcInputOn <= 1'b0;
      end else begin
         if (sampleTick_reg) begin
            lowCnt_reg <= (standbyOn | (&lowCnt_reg)) ?
               (standbyOn ? '0 : lowCnt_reg) : lowCnt_reg + 1'b1;
         end
         almLat_reg <= almEvt | (almLat_reg & {3{~ackNow}});
         remoteActive <= remoteReq;
         dcInputOn <= dcOnNext;
      end
   end

   // Pin outputs, set values and monitors
   wire [VAL_W-1:0] panV = panelVI_reg[VAL_W-1:0];
   wire [VAL_W-1:0] panI = panelVI_reg[16 +: VAL_W];
   wire [VAL_W-1:0] panP = panelPR_reg[VAL_W-1:0];
   wire [VAL_W-1:0] panR = panelPR_reg[16 +: VAL_W];
   wire [VAL_W-1:0] actV = (actualVoltage > FS10) ? FS10 : actualVoltage;
   wire [VAL_W-1:0] actI = (actualCurrent > FS10) ? FS10 : actualCurrent;
   logic [VAL_W-1:0] anaV_reg, anaI_reg, anaP_reg, anaR_reg;
   wire [VAL_W-1:0] resSel = remoteActive ? anaR_reg : panR;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         anaV_reg <= '0;
         anaI_reg <= '0;
         anaP_reg <= '0;
         anaR_reg <= '0;
      end else if (sampleTick_reg) begin
         anaV_reg <= toPercent(voltage_setpoint_in, range5);
         anaI_reg <= toPercent(current_setpoint_in, range5);
         anaP_reg <= toPercent(powerSetpointIn, range5);
         anaR_reg <= toPercent(resistance_setpoint_in, range5);
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         setVoltage <= '0;
         setCurrent <= '0;
         setPower <= '0;
         setResistance <= '0;
         alarmPin1 <= 1'b0;
         alarmPin2 <= 1'b0;
         statusPin <= 1'b0;
         voltage_monitor_out <= '0;
         current_monitor_out <= '0;
      end else begin
         setVoltage <= remoteActive ? anaV_reg : panV;
         setCurrent <= remoteActive ? anaI_reg : panI;
         setPower <= remoteActive ? anaP_reg : panP;
         setResistance <= rModeActive ? resSel : '0;
         alarmPin1 <= overtemperature_alarm | power_fail_alarm;
         alarmPin2 <= |almLat_reg;
         statusPin <= showInput ? ~dcInputOn :
            (regMode != arc_pkg::CONST_VOLTAGE_REGULATION);
         voltage_monitor_out <= range5 ? {1'b0, actV[VAL_W-1:1]} : actV;
         current_monitor_out <= range5 ? {1'b0, actI[VAL_W-1:1]} : actI;
      end
   end

   // Register read path
   logic [31:0] rdWord;
   logic rdOk;
   wire [31:0] statusWord = {21'h0, regMode, standbyOn, alarmPin2,
      alarmPin1, almLat_reg, dcInputOn, rModeActive, remoteActive};
   always_comb begin
      rdOk = 1'b1;
      case (s_axi_araddr)
         arc_pkg::REG_CTRL: rdWord = {29'h0, ctrl_reg};
         arc_pkg::REG_STATUS: rdWord = statusWord;
         arc_pkg::REG_PANEL_VI: rdWord = panelVI_reg;
         arc_pkg::REG_PANEL_PR: rdWord = panelPR_reg;
         arc_pkg::REG_ACT_VI: rdWord = {setCurrent, setVoltage};
         arc_pkg::REG_ACT_PR: rdWord = {setResistance, setPower};
         default: begin
            rdWord = 32'h0;
            rdOk = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         arReady_reg <= 1'b0;
         rValid_reg <= 1'b0;
         rData_reg <= 32'h0;
         rResp_reg <= arc_pkg::RESP_OKAY;
      end else begin
         arReady_reg <= ~rValidNext;
         rValid_reg <= rValidNext;
         if (arTake) begin
            rData_reg <= rdWord;
            rResp_reg <= rdOk ? arc_pkg::RESP_OKAY : arc_pkg::RESP_SLVERR;
         end
      end
   end

   assign s_axi_awready = awReady_reg;
   assign s_axi_wready = wReady_reg;
   assign s_axi_bvalid = bValid_reg;
   assign s_axi_bresp = bResp_reg;
   assign s_axi_arready = arReady_reg;
   assign s_axi_rvalid = rValid_reg;
   assign s_axi_rdata = rData_reg;
   assign s_axi_rresp = rResp_reg;

   // Checks
   a_alarm_input_off: assert property (
      anyAlarm |=> !dcInputOn) else $error("input on during alarm");
   a_alarm1_follow: assert property (
      1'b1 |=> alarmPin1 == $past(overtemperature_alarm | power_fail_alarm))
      else $error("alarm pin 1 wrong");
   a_alarm2_latch: assert property (
      1'b1 |=> alarmPin2 == $past(|almLat_reg))
      else $error("alarm pin 2 wrong");
   a_latch_hold: assert property (
      almLat_reg[0] && !ackNow |=> almLat_reg[0])
      else $error("alarm dropped without ack");
   a_ack_clears: assert property (
      ackNow && almEvt == 3'h0 |=> almLat_reg == 3'h0 ##1 !alarmPin2)
      else $error("ack did not clear alarms");
   a_status_mode: assert property (
      !showInput && regMode == arc_pkg::CONST_VOLTAGE_REGULATION
      |=> !statusPin) else $error("status not low in voltage mode");
   a_status_input: assert property (
      showInput |=> statusPin == !$past(dcInputOn))
      else $error("status not showing input");
   a_remote_standby: assert property (
      remoteActive && !anyAlarm |=> dcInputOn == $past(standbyOn))
      else $error("standby ignored in remote");
   a_local_lock: assert property (
      !remoteActive && !standbyOn |=> !dcInputOn)
      else $error("lock ignored");
   a_set_clamp: assert property (
      anaV_reg <= FS10 && anaI_reg <= FS10)
      else $error("set value above full scale");
   a_pins_on_tick: assert property (
      pinS != $past(pinS) |-> $past(sampleTick_reg))
      else $error("pin level moved off tick");
   c_remote_entry: cover property (!remoteActive ##1 remoteActive);
   c_ack_seen: cover property (ackPin && almLat_reg != 3'h0);
   c_alarm_off: cover property (dcInputOn ##1 !dcInputOn && anyAlarm);
endmodule // arc_analog_remote_ctrl
`default_nettype wire

// >>> logic/arc_pkg.sv
`default_nettype none
package arc_pkg;
   // Clock and sampling
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned SAMPLE_RATE_HZ = 500;
   localparam int unsigned SAMPLE_CYCLES =
      (CLK_HZ + SAMPLE_RATE_HZ - 1) / SAMPLE_RATE_HZ;
   localparam int unsigned SAMPLE_PERIOD_US = 1_000_000 / SAMPLE_RATE_HZ;
   // Alarm acknowledge low phase
   localparam int unsigned ACK_LOW_MS = 50;
   localparam int unsigned ACK_LOW_SAMPLES =
      (ACK_LOW_MS * 1000 + SAMPLE_PERIOD_US - 1) / SAMPLE_PERIOD_US;
   localparam int unsigned LOW_W = 6;
   // Value width and full scale
   localparam int unsigned VAL_W = 16;
   localparam logic [15:0] FULL_SCALE_10V = 16'h6666;
   localparam logic [15:0] FULL_SCALE_5V = 16'h3333;
   // Register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_PANEL_VI = 8'h08;
   localparam logic [7:0] REG_PANEL_PR = 8'h0C;
   localparam logic [7:0] REG_ACT_VI = 8'h10;
   localparam logic [7:0] REG_ACT_PR = 8'h14;
   // Control fields
   localparam int unsigned CTRL_RANGE5_BIT = 0;
   localparam int unsigned CTRL_SHOWIN_BIT = 1;
   localparam int unsigned CTRL_SBINV_BIT = 2;
   localparam int unsigned CTRL_ON_BIT = 3;
   localparam int unsigned CTRL_OFF_BIT = 4;
   localparam int unsigned CTRL_ACK_BIT = 5;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      CONST_VOLTAGE_REGULATION,
      CONST_CURRENT_REGULATION,
      CONST_POWER_REGULATION,
      CONST_RESISTANCE_REGULATION
   } arc_reg_mode_t;
endpackage
`default_nettype wire

// >>> logic/arc_pin_sample.sv
`default_nettype none
module arc_pin_sample #(
   parameter int unsigned W = 3
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Sample strobe
   input wire logic sampleTick,
   // Pins and sampled levels
   input wire logic [W-1:0] pinIn,
   output logic [W-1:0] pinSampled
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;
   logic [W-1:0] held_reg;

   // Idle pins read high through their pull-ups
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= '1;
         sync_reg <= '1;
         held_reg <= '1;
      end else begin
         meta_reg <= pinIn;
         sync_reg <= meta_reg;
         if (sampleTick) begin
            held_reg <= sync_reg;
         end
      end
   end

   assign pinSampled = held_reg;
endmodule // arc_pin_sample
`default_nettype wire

// >>> verification/arc_ctrl_model.sv
`default_nettype none
module arc_ctrl_model #(
   parameter int unsigned START_CYCLES = 40
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Bench commands
   input wire logic wantRemote,
   input wire logic wantResMode,
   input wire logic wantOff,
   input wire logic [15:0] codeV,
   input wire logic [15:0] codeC,
   input wire logic [15:0] codeP,
   input wire logic [15:0] codeR,
   // Socket pins
   output logic remoteSel_b,
   output logic resistanceMode_b,
   output logic input_standby_pin,
   output logic [15:0] pinV,
   output logic [15:0] pinC,
   output logic [15:0] pinP,
   output logic [15:0] pinR,
   input wire logic alarmPin1,
   input wire logic alarmPin2,
   // Controller view
   output logic ready,
   output logic [1:0] alarmView
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned startCnt;
   // Open-collector senders: a released line floats high
   assign remoteSel_b = !wantRemote;
   assign resistanceMode_b = !wantResMode;
   assign input_standby_pin = !wantOff;
   // Every set value stays defined; unused resistance tied to reference
   assign pinV = codeV;
   assign pinC = codeC;
   assign pinP = codeP;
   assign pinR = wantResMode ? codeR : arc_pkg::FULL_SCALE_10V;
   // Alarm pins are ignored until startup has run its course
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         startCnt <= 0;
      end else if (startCnt < START_CYCLES) begin
         startCnt <= startCnt + 1;
      end
   end
   assign ready = (startCnt >= START_CYCLES);
   assign alarmView = ready ? {alarmPin2, alarmPin1} : 2'h0;
endmodule // arc_ctrl_model
`default_nettype wire

// >>> verification/arc_analog_remote_ctrl_tb.sv
`default_nettype none
module arc_analog_remote_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SC = 20;
   localparam int ACKN = arc_pkg::ACK_LOW_SAMPLES;
   logic mclk, rst_b;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, alarmView;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic wantRemote, wantResMode, wantOff, ready;
   logic [15:0] codeV, codeC, codeP, codeR, pinV, pinC, pinP, pinR;
   logic [15:0] actV, actC, monV, monC, setV, setC, setP, setR;
   logic remSel_b, resMode_b, standby, al1, al2, statusPin, dcOn, remAct;
   logic [2:0] evt;
   logic ot, pf;
   arc_pkg::arc_reg_mode_t regMode;
   int n_errors, cmp_count, m;

   arc_analog_remote_ctrl #(.SAMPLE_CYCLES(SC)) dut (
      .mclk(mclk), .rst_b(rst_b),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .remoteSel_b(remSel_b),
      .resistanceMode_b(resMode_b), .input_standby_pin(standby),
      .alarmPin1(al1), .alarmPin2(al2), .statusPin(statusPin),
      .voltage_setpoint_in(pinV), .current_setpoint_in(pinC),
      .powerSetpointIn(pinP), .resistance_setpoint_in(pinR),
      .actualVoltage(actV), .actualCurrent(actC),
      .voltage_monitor_out(monV), .current_monitor_out(monC),
      .overvoltage_alarm(evt[0]), .overcurrent_alarm(evt[1]),
      .overpower_alarm(evt[2]), .overtemperature_alarm(ot),
      .power_fail_alarm(pf), .regMode(regMode),
      .setVoltage(setV), .setCurrent(setC), .setPower(setP),
      .setResistance(setR), .dcInputOn(dcOn), .remoteActive(remAct)
   );

   arc_ctrl_model ctrl (
      .mclk(mclk), .rst_b(rst_b), .wantRemote(wantRemote),
      .wantResMode(wantResMode), .wantOff(wantOff), .codeV(codeV),
      .codeC(codeC), .codeP(codeP), .codeR(codeR), .remoteSel_b(remSel_b),
      .resistanceMode_b(resMode_b), .input_standby_pin(standby),
      .pinV(pinV), .pinC(pinC), .pinP(pinP), .pinR(pinR),
      .alarmPin1(al1), .alarmPin2(al2), .ready(ready),
      .alarmView(alarmView)
   );

   initial begin
      mclk = 1'h0;
      forever #5 mclk = ~mclk;
   end

   task automatic complete_run();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic chk1(input logic s, input logic e);
      check({31'h0, s}, {31'h0, e});
   endtask

   task automatic timedOut();
      n_errors++;
      $display("FAIL %0t bus wait ran out", $time);
      complete_run();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      int i;
      @(posedge mclk);
      awaddr <= a;
      awvalid <= 1'h1;
      wdata <= d;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (i = 0; i < 50; i++) begin
         @(posedge mclk);
         if (awvalid && awready)
            awvalid <= 1'h0;
         if (wvalid && wready)
            wvalid <= 1'h0;
         if (bvalid) begin
            check({30'h0, bresp}, {30'h0, er});
            bready <= 1'h0;
            break;
         end
      end
      if (i == 50)
         timedOut();
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      int i;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (i = 0; i < 50; i++) begin
         @(posedge mclk);
         if (arvalid && arready)
            arvalid <= 1'h0;
         if (rvalid) begin
            check(rdata, ed);
            check({30'h0, rresp}, {30'h0, er});
            rready <= 1'h0;
            break;
         end
      end
      if (i == 50)
         timedOut();
   endtask

   task automatic ticks(input int n);
      repeat (n * SC) @(posedge mclk);
      #1;
   endtask

   task automatic ackPulse(input int n);
      wantOff <= 1'h1;
      ticks(n);
      wantOff <= 1'h0;
   endtask

   initial begin
      rst_b = 1'h0;
      {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
      {arvalid, rready, wantRemote, wantResMode, wantOff} = '0;
      {evt, ot, pf, actV, actC, codeR} = '0;
      wstrb = 4'hF;
      codeV = 16'h0555;
      codeC = 16'h0666;
      codeP = 16'h0777;
      regMode = arc_pkg::CONST_VOLTAGE_REGULATION;
      n_errors = 0;
      cmp_count = 0;
      repeat (8) @(posedge mclk);
      rst_b <= 1'h1;
      rd(arc_pkg::REG_CTRL, 32'h0, arc_pkg::RESP_OKAY);
      rd(8'h18, 32'h0, arc_pkg::RESP_SLVERR);
      wr(arc_pkg::REG_STATUS, 32'hFFFF_FFFF, arc_pkg::RESP_SLVERR);
      wr(arc_pkg::REG_PANEL_VI, 32'h1234_2345, arc_pkg::RESP_OKAY);
      rd(arc_pkg::REG_ACT_VI, 32'h1234_2345, arc_pkg::RESP_OKAY);
      // Local mode: standby low locks the input off
      wantOff <= 1'h1;
      ticks(3);
      wr(arc_pkg::REG_CTRL, 32'h08, arc_pkg::RESP_OKAY);
      ticks(1);
      chk1(dcOn, 1'h0);
      wantOff <= 1'h0;
      ticks(3);
      wr(arc_pkg::REG_CTRL, 32'h08, arc_pkg::RESP_OKAY);
      ticks(1);
      chk1(dcOn, 1'h1);
      wr(arc_pkg::REG_CTRL, 32'h02, arc_pkg::RESP_OKAY);
      ticks(1);
      chk1(statusPin, 1'h0);
      wr(arc_pkg::REG_CTRL, 32'h00, arc_pkg::RESP_OKAY);
      for (m = 0; m < 4; m++) begin
         regMode <= arc_pkg::arc_reg_mode_t'(m);
         ticks(1);
         chk1(statusPin, m != 0);
      end
      // Latched alarm; standby pulse outside remote must not clear it
      evt <= 3'h1;
      @(posedge mclk);
      evt <= 3'h0;
      ticks(1);
      chk1(dcOn, 1'h0);
      chk1(alarmView[1], 1'h1);
      ackPulse(ACKN + 1);
      ticks(2);
      chk1(alarmView[1], 1'h1);
      // Remote mode
      codeV <= 16'h7000;
      codeC <= 16'h1111;
      codeP <= 16'h2222;
      codeR <= 16'h3333;
      actV <= 16'h2000;
      actC <= 16'h7000;
      wantRemote <= 1'h1;
      repeat (2) @(posedge mclk);
      #1;
      chk1(remAct, 1'h0);
      ticks(3);
      chk1(remAct, 1'h1);
      check({16'h0, setV}, {16'h0, arc_pkg::FULL_SCALE_10V});
      check({setP, setC}, 32'h2222_1111);
      check({16'h0, setR}, 32'h0);
      check({16'h0, monV}, 32'h2000);
      check({16'h0, monC}, 32'h6666);
      ackPulse(3);
      ticks(3);
      chk1(alarmView[1], 1'h1);
      ackPulse(ACKN + 1);
      ticks(3);
      chk1(alarmView[1], 1'h0);
      chk1(dcOn, 1'h1);
      wantOff <= 1'h1;
      ticks(2);
      chk1(dcOn, 1'h0);
      wantOff <= 1'h0;
      wantResMode <= 1'h1;
      ticks(2);
      check({16'h0, setR}, 32'h3333);
      wr(arc_pkg::REG_CTRL, 32'h01, arc_pkg::RESP_OKAY);
      ticks(2);
      check({16'h0, setV}, 32'h6666);
      check({16'h0, monV}, 32'h1000);
      check({16'h0, monC}, 32'h3333);
      ot <= 1'h1;
      ticks(1);
      chk1(alarmView[0], 1'h1);
      ot <= 1'h0;
      pf <= 1'h1;
      ticks(1);
      chk1(alarmView[0], 1'h1);
      pf <= 1'h0;
      ticks(1);
      chk1(alarmView[0], 1'h0);
      for (m = 0; m < 3; m++) begin
         evt <= 3'h1 << m;
         @(posedge mclk);
         evt <= 3'h0;
         ticks(1);
         chk1(alarmView[1], 1'h1);
         chk1(dcOn, 1'h0);
         ackPulse(ACKN + 1);
         ticks(3);
         chk1(alarmView[1], 1'h0);
      end
      // Inverted standby polarity: a high pin now switches the input off
      wr(arc_pkg::REG_CTRL, 32'h04, arc_pkg::RESP_OKAY);
      ticks(1);
      chk1(dcOn, 1'h0);
      wr(arc_pkg::REG_CTRL, 32'h00, arc_pkg::RESP_OKAY);
      ticks(1);
      chk1(dcOn, 1'h1);
      wantRemote <= 1'h0;
      ticks(3);
      chk1(remAct, 1'h0);
      rd(arc_pkg::REG_ACT_VI, 32'h1234_2345, arc_pkg::RESP_OKAY);
      rd(arc_pkg::REG_STATUS, 32'h0000_0706, arc_pkg::RESP_OKAY);
      // Local off command, then a software acknowledge
      wr(arc_pkg::REG_CTRL, 32'h10, arc_pkg::RESP_OKAY);
      ticks(1);
      chk1(dcOn, 1'h0);
      evt <= 3'h4;
      @(posedge mclk);
      evt <= 3'h0;
      ticks(1);
      chk1(alarmView[1], 1'h1);
      wr(arc_pkg::REG_CTRL, 32'h20, arc_pkg::RESP_OKAY);
      ticks(1);
      chk1(alarmView[1], 1'h0);
      complete_run();
   end
endmodule // arc_analog_remote_ctrl_tb
`default_nettype wire
